//--- eep_pkg.sv
`default_nettype none
package eep_pkg;

  // Array geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int DEPTH = 4096;

  // Byte framing: eight data bits, then the acknowledge slot
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  localparam logic [3:0] BIT_FIRST = 4'h0;

  // Address pointer reset value
  localparam logic [11:0] PTR_RESET = 12'h000;

  // Device type code; the value is arbitrary
  localparam logic [3:0] DEVICE_TYPE_DEF = 4'h5;

  // Internal write cycle time and the system clock period
  localparam int WRITE_TIME_NS_DEF = 5000000;
  localparam int SYS_CLK_NS = 40;
  localparam int CNT_W = 24;

  // Protocol engine states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CTRL = 7'h02,
    ST_ADRH = 7'h04,
    ST_ADRL = 7'h08,
    ST_WDATA = 7'h10,
    ST_RDATA = 7'h20,
    ST_SPARE = 7'h40
  } eep_state_t;

endpackage
`default_nettype wire

//--- eep_mem.sv
`timescale 1ns/1ps
`default_nettype none
module eep_mem
  import eep_pkg::*;
(
  input wire logic clk_i, // Array clock
  input wire logic reset_n_i, // Async reset, active low
  input wire logic we_i, // Write strobe, one cycle
  input wire logic [ADDR_W-1:0] waddr_i, // Write address
  input wire logic [DATA_W-1:0] wdata_i, // Write data
  input wire logic [ADDR_W-1:0] raddr_i, // Read address
  output logic [DATA_W-1:0] rdata_o // Registered read data
);

  // Storage cells, no reset so they map onto RAM
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [DATA_W-1:0] rdata_ff; // Read register

  // Write port
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // Read port, one cycle of latency
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_ff <= '0;
    end
    else
    begin
      rdata_ff <= mem_q[raddr_i];
    end
  end

  assign rdata_o = rdata_ff;

endmodule
`default_nettype wire

//--- eep_client.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// R01 - WP high blocks writes to whole array
// R02 - WP low lets writes program normally
// R03 - WP sampled at the Stop of write
// R04 - Later WP changes leave running cycle alone
// R05 - No acknowledge while write cycle runs
// R06 - Stop after write starts timed cycle
// R07 - Host polls with write control byte
// R08 - Host repeats Start and control byte
// R09 - Acknowledge poll once cycle has finished
// R10 - Read is direction bit set high
// R11 - Pointer holds last location plus one
// R12 - Current read: ack, send pointer byte
// R13 - Host nack plus Stop ends single read
// R14 - Address load kept despite abandoned write
// R15 - Repeated Start read: ack, send, stop
// R16 - After random read pointer is next
// R17 - Host ack requests next sequential byte
// R18 - Host ends sequential read with nack
// R19 - Pointer increments after each byte
// R20 - Pointer wraps from top to bottom
// R21 - Protected write acked, nothing programmed, ready
// R22 - Control byte type and chip select match
// R23 - Two address bytes, twelve bits used
// R24 - Release data line after host nack
// R25 - Write cycle duration is a parameter
// R26 - Busy device ignores bytes, keeps pointer
module eep_client
  import eep_pkg::*;
#(
  parameter int WRITE_TIME_NS = eep_pkg::WRITE_TIME_NS_DEF, // Internal write cycle time
  parameter logic [3:0] DEVICE_TYPE = eep_pkg::DEVICE_TYPE_DEF // Type code; value is arbitrary
)
(
  input wire logic clk_sys_i, // System clock, 25 MHz
  input wire logic reset_n_i, // Async reset, active low
  input wire logic clk_link_i, // Link clock, samples the bus pins
  input wire logic scl_i, // Bus clock from host
  input wire logic sda_i, // Bus data line level
  output logic sda_o, // Data drive value, always low
  output logic sda_oe_o, // High while pulling data low
  input wire logic wp_i, // Write protect pin
  input wire logic chip_select_bit2_i, // Chip select pin 2
  input wire logic chip_select_bit1_i, // Chip select pin 1
  input wire logic chip_select_bit0_i, // Chip select pin 0
  output logic write_busy_o // Internal write cycle running
);

  // Least time rounds up, never below one cycle
  localparam int WRITE_CYC_RAW = (WRITE_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [CNT_W-1:0] WRITE_CYCLES = CNT_W'((WRITE_CYC_RAW < 1) ? 1 : WRITE_CYC_RAW); // R25

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: pin synchronisers and bus condition detection

  logic [5:0] pin_s1_ff; // First stage, read only by second
  logic [5:0] pin_s2_ff; // Second stage
  logic scl_d_ff; // Previous clock level
  logic sda_d_ff; // Previous data level
  logic scl_s; // Synchronised clock
  logic sda_s; // Synchronised data
  logic wp_s; // Synchronised write protect
  logic [2:0] cs_s; // Synchronised chip selects
  logic start_det; // Start or repeated Start
  logic stop_det; // Stop
  logic scl_rise; // Bus clock rising
  logic scl_fall; // Bus clock falling

  // Every pin passes two flops before use
  always_ff @(posedge clk_link_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pin_s1_ff <= 6'h3f;
      pin_s2_ff <= 6'h3f;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      pin_s1_ff <= {scl_i, sda_i, wp_i, chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i};
      pin_s2_ff <= pin_s1_ff;
      scl_d_ff <= pin_s2_ff[5];
      sda_d_ff <= pin_s2_ff[4];
    end
  end

  assign scl_s = pin_s2_ff[5];
  assign sda_s = pin_s2_ff[4];
  assign wp_s = pin_s2_ff[3];
  assign cs_s = pin_s2_ff[2:0];
  assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;
  assign scl_rise = scl_s && !scl_d_ff;
  assign scl_fall = !scl_s && scl_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: protocol engine

  eep_state_t state_ff; // Engine state
  logic [3:0] bit_cnt_ff; // Bit position within byte
  logic [7:0] shift_ff; // Receive or transmit shifter
  logic sda_oe_ff; // Data line pull-down
  logic [ADDR_W-1:0] ptr_ff; // Address pointer
  logic [3:0] adr_hi_ff; // Upper address nibble
  logic have_data_ff; // A data byte awaits the Stop
  logic [ADDR_W-1:0] wr_addr_ff; // Address to program
  logic [DATA_W-1:0] wr_data_ff; // Data to program
  logic launch_tgl_ff; // Flips once per write cycle launch
  logic [1:0] done_sync_ff; // Write-done toggle synchroniser
  logic done_tgl_ff; // Flips when a cycle ends, system domain
  logic link_busy; // Write cycle in progress
  logic ctrl_match; // Control byte addresses us
  logic ack_ok; // Acknowledge this byte
  logic mem_we; // Program the array
  logic [DATA_W-1:0] rd_data; // Byte at the pointer

  assign link_busy = launch_tgl_ff ^ done_sync_ff[1];
  assign ctrl_match = (shift_ff[7:1] == {DEVICE_TYPE, cs_s}); // R22

  // Decide whether the byte just received earns an acknowledge
  always_comb
  begin
    ack_ok = 1'b1;
    if (state_ff == ST_CTRL)
    begin
      ack_ok = ctrl_match && !link_busy; // R05 R09 R26
    end
  end

  // Bit sequencing and data line drive
  always_ff @(posedge clk_link_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= BIT_FIRST;
      shift_ff <= 8'h00;
      sda_oe_ff <= 1'b0;
    end
    else if (start_det)
    begin
      // Start always resynchronises, even mid-byte
      state_ff <= ST_CTRL;
      bit_cnt_ff <= BIT_FIRST;
      sda_oe_ff <= 1'b0;
    end
    else if (stop_det)
    begin
      state_ff <= ST_IDLE; // R13 R15
      bit_cnt_ff <= BIT_FIRST;
      sda_oe_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE, ST_SPARE:
        begin
          // Wait for a Start; ignores everything else
          sda_oe_ff <= 1'b0;
        end
        ST_RDATA:
        begin
          // Transmit, MSB first, then sample host acknowledge
          if (scl_rise && bit_cnt_ff < BIT_LAST)
          begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          else if (scl_rise && bit_cnt_ff == BIT_LAST)
          begin
            if (sda_s)
            begin
              state_ff <= ST_IDLE; // R24
              bit_cnt_ff <= BIT_FIRST;
            end
            else
            begin
              bit_cnt_ff <= BIT_ACK; // R17
            end
          end
          else if (scl_fall && bit_cnt_ff != BIT_FIRST && bit_cnt_ff < BIT_LAST)
          begin
            shift_ff <= {shift_ff[6:0], 1'b0};
            sda_oe_ff <= !shift_ff[6];
          end
          else if (scl_fall && bit_cnt_ff == BIT_LAST)
          begin
            sda_oe_ff <= 1'b0; // R24
          end
          else if (scl_fall && bit_cnt_ff == BIT_ACK)
          begin
            shift_ff <= rd_data; // R17
            sda_oe_ff <= !rd_data[7];
            bit_cnt_ff <= BIT_FIRST;
          end
        end
        default:
        begin
          // Receive states: control, address high, address low, data
          if (scl_rise && bit_cnt_ff < BIT_LAST)
          begin
            shift_ff <= {shift_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          else if (scl_rise && bit_cnt_ff == BIT_LAST)
          begin
            bit_cnt_ff <= BIT_ACK;
          end
          else if (scl_fall && bit_cnt_ff == BIT_LAST)
          begin
            sda_oe_ff <= ack_ok; // R05 R21 R22
            if (!ack_ok)
            begin
              state_ff <= ST_IDLE; // R26
              bit_cnt_ff <= BIT_FIRST;
            end
          end
          else if (scl_fall && bit_cnt_ff == BIT_ACK)
          begin
            sda_oe_ff <= 1'b0;
            bit_cnt_ff <= BIT_FIRST;
            if (state_ff == ST_CTRL && shift_ff[0])
            begin
              // Read: first byte already waits at the pointer
              state_ff <= ST_RDATA; // R10 R12
              shift_ff <= rd_data;
              sda_oe_ff <= !rd_data[7];
            end
            else if (state_ff == ST_CTRL)
            begin
              state_ff <= ST_ADRH;
            end
            else if (state_ff == ST_ADRH)
            begin
              state_ff <= ST_ADRL; // R23
            end
            else
            begin
              state_ff <= ST_WDATA;
            end
          end
        end
      endcase
    end
  end

  // Protected writes never program and never start a cycle
  assign mem_we = stop_det && have_data_ff && !wp_s; // R01 R02 R03 R21

  // Pointer, write holding registers and cycle launch
  always_ff @(posedge clk_link_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ptr_ff <= PTR_RESET;
      adr_hi_ff <= 4'h0;
      have_data_ff <= 1'b0;
      wr_addr_ff <= PTR_RESET;
      wr_data_ff <= 8'h00;
      launch_tgl_ff <= 1'b0;
    end
    else if (start_det)
    begin
      have_data_ff <= 1'b0; // R14
    end
    else if (stop_det)
    begin
      have_data_ff <= 1'b0;
      if (mem_we)
      begin
        launch_tgl_ff <= !launch_tgl_ff; // R06
      end
    end
    else if (scl_fall && bit_cnt_ff == BIT_ACK && state_ff == ST_ADRH)
    begin
      adr_hi_ff <= shift_ff[3:0]; // R23
    end
    else if (scl_fall && bit_cnt_ff == BIT_ACK && state_ff == ST_ADRL)
    begin
      ptr_ff <= {adr_hi_ff, shift_ff}; // R14
    end
    else if (scl_fall && bit_cnt_ff == BIT_ACK && state_ff == ST_WDATA)
    begin
      // Latest byte wins; it is programmed at its own address
      wr_addr_ff <= ptr_ff;
      wr_data_ff <= shift_ff;
      have_data_ff <= 1'b1;
      ptr_ff <= ptr_ff + 12'h001; // R19
    end
    else if (scl_rise && bit_cnt_ff == BIT_LAST && state_ff == ST_RDATA)
    begin
      // Natural 12-bit wrap takes the top back to zero
      ptr_ff <= ptr_ff + 12'h001; // R11 R16 R19 R20
    end
  end

  // Write-done toggle back from the system domain
  always_ff @(posedge clk_link_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      done_sync_ff <= 2'b00;
    end
    else
    begin
      done_sync_ff <= {done_sync_ff[0], done_tgl_ff};
    end
  end

  // Array; read address follows the pointer at all times
  eep_mem u_mem (
    .clk_i(clk_link_i),
    .reset_n_i(reset_n_i),
    .we_i(mem_we),
    .waddr_i(wr_addr_ff),
    .wdata_i(wr_data_ff),
    .raddr_i(ptr_ff),
    .rdata_o(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // System domain: internally timed write cycle

  logic [2:0] launch_sync_ff; // Launch toggle sync plus edge stage
  logic [CNT_W-1:0] timer_ff; // Remaining cycle time
  logic sys_busy_ff; // Cycle running
  logic launch_evt; // New cycle requested

  assign launch_evt = launch_sync_ff[1] ^ launch_sync_ff[2];

  // Timer runs on its own clock, so pin changes cannot touch it
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      launch_sync_ff <= 3'b000;
      timer_ff <= '0;
      sys_busy_ff <= 1'b0;
      done_tgl_ff <= 1'b0;
    end
    else
    begin
      launch_sync_ff <= {launch_sync_ff[1:0], launch_tgl_ff};
      if (launch_evt)
      begin
        timer_ff <= WRITE_CYCLES; // R04 R25
        sys_busy_ff <= 1'b1;
      end
      else if (sys_busy_ff && timer_ff > CNT_W'(1))
      begin
        timer_ff <= timer_ff - CNT_W'(1);
      end
      else if (sys_busy_ff)
      begin
        timer_ff <= '0;
        sys_busy_ff <= 1'b0;
        done_tgl_ff <= !done_tgl_ff; // R09
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_ff;
  assign write_busy_o = sys_busy_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_busy_noack;
    @(posedge clk_link_i) disable iff (!reset_n_i)
    (state_ff == ST_CTRL && link_busy && scl_fall && bit_cnt_ff == BIT_LAST) |=> !sda_oe_ff ##1 !sda_oe_ff;
  endproperty
  a_busy_noack: assert property (p_busy_noack) else $error("acknowledge given while busy"); // R05

  property p_wp_block;
    @(posedge clk_link_i) disable iff (!reset_n_i)
    (stop_det && have_data_ff && wp_s) |=> $stable(launch_tgl_ff) && !have_data_ff;
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("protected write launched"); // R01

  property p_wp_open;
    @(posedge clk_link_i) disable iff (!reset_n_i)
    (stop_det && have_data_ff && !wp_s) |=> link_busy ##1 link_busy;
  endproperty
  a_wp_open: assert property (p_wp_open) else $error("write cycle did not start"); // R06

  property p_ptr_load;
    @(posedge clk_link_i) disable iff (!reset_n_i)
    (!start_det && !stop_det && state_ff == ST_ADRL && scl_fall && bit_cnt_ff == BIT_ACK)
      |=> ptr_ff == {$past(adr_hi_ff), $past(shift_ff)} && state_ff == ST_WDATA;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded"); // R14

  property p_read_inc;
    @(posedge clk_link_i) disable iff (!reset_n_i)
    (!start_det && !stop_det && state_ff == ST_RDATA && scl_rise && bit_cnt_ff == BIT_LAST)
      |=> ptr_ff == $past(ptr_ff) + 12'h001;
  endproperty
  a_read_inc: assert property (p_read_inc) else $error("pointer did not advance"); // R19

  property p_wrap;
    @(posedge clk_link_i) disable iff (!reset_n_i)
    (!start_det && !stop_det && state_ff == ST_RDATA && scl_rise && bit_cnt_ff == BIT_LAST && ptr_ff == 12'hfff)
      |=> ptr_ff == 12'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap"); // R20

  property p_nack_release;
    @(posedge clk_link_i) disable iff (!reset_n_i)
    (!start_det && !stop_det && state_ff == ST_RDATA && scl_rise && bit_cnt_ff == BIT_LAST && sda_s)
      |=> state_ff == ST_IDLE && !sda_oe_ff ##1 !sda_oe_ff;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("data line held after nack"); // R24

  property p_mismatch;
    @(posedge clk_link_i) disable iff (!reset_n_i)
    (!start_det && !stop_det && state_ff == ST_CTRL && scl_fall && bit_cnt_ff == BIT_LAST && !ctrl_match)
      |=> !sda_oe_ff && state_ff == ST_IDLE;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("foreign control byte acknowledged"); // R22

  property p_timer;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    launch_evt |=> sys_busy_ff && timer_ff == WRITE_CYCLES;
  endproperty
  a_timer: assert property (p_timer) else $error("write timer not loaded"); // R25

  c_seq_read: cover property (@(posedge clk_link_i) disable iff (!reset_n_i)
    state_ff == ST_RDATA && scl_fall && bit_cnt_ff == BIT_ACK);
  c_wrap: cover property (@(posedge clk_link_i) disable iff (!reset_n_i)
    state_ff == ST_RDATA && scl_rise && bit_cnt_ff == BIT_LAST && ptr_ff == 12'hfff && !sda_s);
  c_wp_block: cover property (@(posedge clk_link_i) disable iff (!reset_n_i)
    stop_det && have_data_ff && wp_s);
  c_busy_poll: cover property (@(posedge clk_link_i) disable iff (!reset_n_i)
    state_ff == ST_CTRL && link_busy && scl_fall && bit_cnt_ff == BIT_LAST && ctrl_match);

endmodule
`default_nettype wire

//--- eep_host_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Bus host model: clock driven directly, open-drain data drive; the pull-up makes a released data line read high
module eep_host_model (
  input wire logic sda_i, // Resolved data line level
  output logic scl_o, // Bus clock, stands high between frames
  output logic sda_o // Data drive, 1 releases the line
);
  // Quarter bit time of four system clocks, so pin changes keep their offset from the clock edge
  // Each 320 ns clock phase is well over four link clocks
  localparam int Q = 160;
  // Idle bus: both lines released
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // Start, or repeated Start when the clock is low
  task automatic start();
    #Q sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
  endtask
  // Stop: data rises while the clock is high, then the bus idles
  task automatic stop();
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask
  // One bit: data moves only while the clock is low, sampled in the high phase
  task automatic bit_x(input logic b, output logic r);
    #Q sda_o = b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
  endtask
  // Byte to the device, MSB first; the ninth clock reads the answer
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // Byte from the device; an ack asks for more, a nack ends the read
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(~ack, r);
  endtask
  // Poll with the write control byte until acknowledged; capped so a dead device cannot hang
  task automatic poll(input logic [7:0] ctl, output logic ack, output int n);
    n = 0;
    do
    begin
      start();
      wr_byte(ctl, ack);
      stop();
      n++;
    end while (!ack && n < 40);
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
module tb_top;
  import eep_pkg::*;
  // Write cycle of 500 system clocks, long enough for several polls
  localparam int WT = 20000;
  logic clk_sys_i, clk_link_i, reset_n_i, wp_i, scl, host_sda, sda, sda_o, sda_oe_o, write_busy_o;
  logic [2:0] cs; // Chip select pins
  logic [11:0] ptr; // Expected address pointer
  logic [7:0] shadow [int]; // Expected array contents
  int mismatches, num_checks;
  // Wired-AND of host and device drives
  assign sda = host_sda & (sda_oe_o ? sda_o : 1'b1);
  eep_client #(.WRITE_TIME_NS(WT), .DEVICE_TYPE(DEVICE_TYPE_DEF)) i_eep_client (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_link_i(clk_link_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i), .chip_select_bit2_i(cs[2]),
    .chip_select_bit1_i(cs[1]), .chip_select_bit0_i(cs[0]), .write_busy_o(write_busy_o));
  eep_host_model i_eep_host_model (.sda_i(sda), .scl_o(scl), .sda_o(host_sda));
  // Clocks: 40 ns system, 30 ns link
  always #20 clk_sys_i = ~clk_sys_i;
  always #15 clk_link_i = ~clk_link_i;
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] ctl(input logic rw);
    return {DEVICE_TYPE_DEF, cs, rw};
  endfunction
  task automatic chk1(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %0t %s: got %b want %b", $time, what, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Byte write; protect pin at one level for the body, another just before the Stop
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic wp_body, input logic wp_stop);
    logic ack;
    logic [7:0] b [4];
    b = '{ctl(1'b0), {4'($urandom), a[11:8]}, a[7:0], d};
    wp_i = wp_body;
    i_eep_host_model.start();
    for (int i = 0; i < 4; i++)
    begin
      i_eep_host_model.wr_byte(b[i], ack);
      chk1(ack, 1'b1, "write byte ack");
    end
    wp_i = wp_stop;
    i_eep_host_model.stop();
    if (!wp_stop)
      shadow[a] = d;
    ptr = a + 12'h001;
  endtask
  // Random read if rnd is set, else current address read; n bytes, the last one nacked
  task automatic rd(input logic rnd, input logic [11:0] a, input int n);
    logic ack;
    logic [7:0] d;
    if (rnd)
    begin
      i_eep_host_model.start();
      i_eep_host_model.wr_byte(ctl(1'b0), ack);
      i_eep_host_model.wr_byte({4'h0, a[11:8]}, ack);
      i_eep_host_model.wr_byte(a[7:0], ack);
      ptr = a;
    end
    i_eep_host_model.start();
    i_eep_host_model.wr_byte(ctl(1'b1), ack);
    chk1(ack, 1'b1, "read ctrl ack");
    for (int i = 0; i < n; i++)
    begin
      i_eep_host_model.rd_byte(i < n - 1, d);
      chk8(d, shadow[int'(ptr)], "read data");
      ptr = ptr + 12'h001;
    end
    i_eep_host_model.stop();
    chk1(sda_oe_o, 1'b0, "data line released");
  endtask
  // Wait for the timed cycle to start, then poll through it
  task automatic poll_busy();
    logic ack;
    int n;
    for (int i = 0; i < 20 && !write_busy_o; i++)
    begin
      @(posedge clk_sys_i);
      #1;
    end
    chk1(write_busy_o, 1'b1, "busy after stop");
    i_eep_host_model.poll(ctl(1'b0), ack, n);
    chk1(ack, 1'b1, "poll ack");
    chk1(logic'(n > 1), 1'b1, "poll nacked while busy");
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic ack;
    logic [11:0] a;
    logic [7:0] d0;
    int n;
    clk_sys_i = 1'b0;
    clk_link_i = 1'b0;
    reset_n_i = 1'b0;
    wp_i = 1'b0;
    cs = 3'h0;
    void'($urandom(93));
    repeat (5) @(posedge clk_sys_i);
    #1 reset_n_i = 1'b1;
    cs = 3'($urandom);
    chk1(sda_oe_o, 1'b0, "idle data line");
    chk1(write_busy_o, 1'b0, "idle busy");
    repeat (4) @(posedge clk_sys_i);
    #1;
    // Wrong type code, then wrong chip select: both ignored
    for (int i = 0; i < 2; i++)
    begin
      i_eep_host_model.start();
      i_eep_host_model.wr_byte(i == 0 ? {DEVICE_TYPE_DEF ^ 4'h3, cs, 1'b0} : {DEVICE_TYPE_DEF, ~cs, 1'b0}, ack);
      i_eep_host_model.stop();
      chk1(ack, 1'b0, "foreign ctrl ignored");
    end
    // Random rounds; the last straddles the top of the array
    for (int k = 0; k < 3; k++)
    begin
      a = (k == 2) ? 12'hfff : 12'($urandom);
      d0 = 8'($urandom);
      wr(a + 12'h001, 8'($urandom), 1'b1, 1'b0);
      poll_busy();
      wr(a, d0, 1'b0, 1'b0);
      @(posedge clk_sys_i);
      #1 wp_i = 1'b1;
      i_eep_host_model.start();
      i_eep_host_model.wr_byte(ctl(1'b1), ack);
      i_eep_host_model.stop();
      chk1(ack, 1'b0, "read ignored while busy");
      poll_busy();
      rd(1'b0, a, 1);
      rd(1'b1, a, 2);
      // Protected write: acked, never programmed, no busy
      wr(a, ~d0, 1'b1, 1'b1);
      repeat (20) @(posedge clk_sys_i);
      #1;
      chk1(write_busy_o, 1'b0, "no cycle when protected");
      i_eep_host_model.poll(ctl(1'b0), ack, n);
      chk1(logic'(n == 1), 1'b1, "protected write ready at once");
      rd(1'b1, a, 1);
      rd(1'b0, a, 1);
    end
    results();
  end
  // Watchdog, well beyond the expected run time
  initial
  begin
    #3000000;
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
